// *** lpm_port_mux.sv ***
/*
 * lpm_port_mux: shared-function pin multiplexer with its register file.
 * Assumes an AHB-Lite master, pin inputs synchronous to hclk, and
 * external serial engines, beep divider and interrupt controller.
 */
`timescale 1ns/1ps
`default_nettype none

module lpm_port_mux
	import lpm_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = LPM_FRAME_CYCLES
) (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire logic                   clock_stop,
	input  wire logic                   beep_tone,
	input  wire lpm_sio_drv_type        sio1_drv,
	input  wire lpm_sio_drv_type        sio2_drv,
	input  wire logic [3:0]             irq_port_in,
	input  wire logic [15:0]            shared_pin_in,
	output logic      [3:0]             open_drain_oe,
	output logic      [3:0]             irq_port_out,
	output logic      [3:0]             irq_port_oe,
	output logic                        ext_irq_a,
	output logic                        ext_irq_b,
	output logic      [2:0][1:0]        lcd_common,
	output logic      [31:0][1:0]       lcd_seg_level,
	output lpm_pin_drive_type [15:0]    shared_pin,
	output lpm_sio_recv_type            sio1_recv,
	output lpm_sio_recv_type            sio2_recv
);

	// ==========================================================
	// functions
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction

	// ==========================================================
	// register state
	logic [3:0]       pcw [16];
	logic [2:0]       status;
	logic [3:0]       beep_ctrl;
	logic [23:0]      latch;
	logic [31:0]      pwm_duty;
	logic [2:0][31:0] seg_data;
	logic             wr_pend;
	logic [7:0]       wr_addr;
	logic [19:0]      pin_in_view;

	// ==========================================================
	// ahb-lite slave: zero wait, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// capture write address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel & htrans[1] & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// read data, registered at the address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr[7:6] == 2'b00) begin
				hrdata <= {28'h0000000, pcw[haddr[5:2]]};
			end else if (reg_hit(haddr[7:0], LPM_REG_STATUS)) begin
				hrdata <= {29'h00000000, status};
			end else if (reg_hit(haddr[7:0], LPM_REG_BEEP)) begin
				hrdata <= {28'h0000000, beep_ctrl};
			end else if (reg_hit(haddr[7:0], LPM_REG_LATCH)) begin
				hrdata <= {8'h00, latch};
			end else if (reg_hit(haddr[7:0], LPM_REG_PWM)) begin
				hrdata <= pwm_duty;
			end else if (reg_hit(haddr[7:0], LPM_REG_SEG0)) begin
				hrdata <= seg_data[0];
			end else if (reg_hit(haddr[7:0], LPM_REG_SEG1)) begin
				hrdata <= seg_data[1];
			end else if (reg_hit(haddr[7:0], LPM_REG_SEG2)) begin
				hrdata <= seg_data[2];
			end else if (reg_hit(haddr[7:0], LPM_REG_PIN_IN)) begin
				hrdata <= {12'h000, pin_in_view};
			end else begin
				hrdata <= 32'h00000000;
			end
		end
	end

	// port control words: one command write replaces one whole word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 16; i++) begin
				pcw[i] <= LPM_PCW_RESET;
			end
		end else if (wr_pend && reg_hit(wr_addr, LPM_REG_PCW_CMD)) begin
			pcw[hwdata[7:4]] <= hwdata[3:0];
		end
	end

	// status, beep and data registers; latches never touched by pcw writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status    <= 3'h0;
			beep_ctrl <= 4'h0;
			latch     <= LPM_LATCH_RESET;
			pwm_duty  <= 32'h00000000;
			seg_data  <= '0;
		end else if (wr_pend) begin
			if (reg_hit(wr_addr, LPM_REG_STATUS)) begin
				status <= hwdata[2:0];
			end else if (reg_hit(wr_addr, LPM_REG_BEEP)) begin
				beep_ctrl <= hwdata[3:0];
			end else if (reg_hit(wr_addr, LPM_REG_LATCH)) begin
				latch <= hwdata[23:0];
			end else if (reg_hit(wr_addr, LPM_REG_PWM)) begin
				pwm_duty <= hwdata;
			end else if (reg_hit(wr_addr, LPM_REG_SEG0)) begin
				seg_data[0] <= hwdata;
			end else if (reg_hit(wr_addr, LPM_REG_SEG1)) begin
				seg_data[1] <= hwdata;
			end else if (reg_hit(wr_addr, LPM_REG_SEG2)) begin
				seg_data[2] <= hwdata;
			end
		end
	end

	// ==========================================================
	// open-drain pwm pins
	logic [3:0] pwm_high;
	logic [3:0] next_od_oe;

	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_pwm
			lpm_pwm_chan u_pwm (
				.hclk     (hclk),
				.hresetn  (hresetn),
				.duty     (pwm_duty[gp*8 +: 8]),
				.pwm_high (pwm_high[gp])
			);

			// transistor on pulls the pin low
			always_comb begin
				if (clock_stop) begin
					next_od_oe[gp] = 1'b0;
				end else if (pcw[LPM_PCW_J_SEL][gp]) begin
					next_od_oe[gp] = ~pwm_high[gp];
				end else begin
					next_od_oe[gp] = ~latch[LPM_LAT_J + gp];
				end
			end
		end
	endgenerate

	// open-drain enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_drain_oe <= 4'h0;
		end else begin
			open_drain_oe <= next_od_oe;
		end
	end

	// ==========================================================
	// interrupt-capable port
	logic [3:0] irq_en_pin;
	logic [3:0] next_k_oe;
	logic [3:0] k_in_live;
	logic [3:0] k_prev;
	logic [1:0] k_edge;

	assign irq_en_pin = {2'b00, status[LPM_ST_IRQ_B], status[LPM_ST_IRQ_A]};
	assign next_k_oe  = clock_stop ? 4'h0 :
		(pcw[LPM_PCW_K_DIR] & ~irq_en_pin);
	assign k_in_live  = clock_stop ? 4'h0 : (irq_port_in & ~irq_port_oe);

	// per-pin edge choice: 1 rising, 0 falling
	assign k_edge[0] = pcw[LPM_PCW_EDGE][0] ? (k_in_live[0] & ~k_prev[0]) :
		(~k_in_live[0] & k_prev[0]);
	assign k_edge[1] = pcw[LPM_PCW_EDGE][1] ? (k_in_live[1] & ~k_prev[1]) :
		(~k_in_live[1] & k_prev[1]);

	// port drivers and edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_port_oe  <= 4'h0;
			irq_port_out <= 4'h0;
			k_prev       <= 4'h0;
		end else begin
			irq_port_oe  <= next_k_oe;
			irq_port_out <= latch[LPM_LAT_K +: 4];
			k_prev       <= k_in_live;
		end
	end

	// interrupt requests, one-cycle pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_irq_a <= 1'b0;
			ext_irq_b <= 1'b0;
		end else begin
			ext_irq_a <= k_edge[0] & status[LPM_ST_IRQ_A] & status[LPM_ST_MASTER];
			ext_irq_b <= k_edge[1] & status[LPM_ST_IRQ_B] & status[LPM_ST_MASTER];
		end
	end

	// ==========================================================
	// lcd waveforms
	lpm_lcd_wave #(
		.FRAME_CYCLES (FRAME_CYCLES)
	) u_lcd (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (~clock_stop),
		.seg_data (seg_data),
		.com_lvl  (lcd_common),
		.seg_lvl  (lcd_seg_level)
	);

	// ==========================================================
	// shared segment / port pins
	lpm_pin_drive_type [15:0] next_pin;
	logic [15:0]              seg_mode;
	logic [15:0]              port_in_live;
	logic                     sio1_on;
	logic                     sio2_on;

	assign sio1_on = pcw[LPM_PCW_SIO_SEL][LPM_SIO1_BIT];
	assign sio2_on = pcw[LPM_PCW_SIO_SEL][LPM_SIO2_BIT];

	genvar gs;
	generate
		for (gs = 0; gs < 16; gs++) begin : g_shared
			localparam lpm_group_type GRP = lpm_group_type'(gs / 4);
			localparam int unsigned   B   = gs % 4;

			// segment or port per pin / group
			always_comb begin
				case (GRP)
					LPM_GRP_E: seg_mode[gs] = ~pcw[LPM_PCW_E_SEG][B];
					LPM_GRP_F: seg_mode[gs] = ~pcw[LPM_PCW_GRP_SEG][LPM_SEG_F_BIT];
					LPM_GRP_M: seg_mode[gs] = ~pcw[LPM_PCW_GRP_SEG][LPM_SEG_M_BIT];
					default:   seg_mode[gs] = ~pcw[LPM_PCW_GRP_SEG][LPM_SEG_N_BIT];
				endcase
			end

			// pin drive per function
			always_comb begin
				next_pin[gs] = '0;
				if (seg_mode[gs]) begin
					next_pin[gs].seg_en = 1'b1;
					next_pin[gs].lvl    = clock_stop ? LPM_LVL_VSS : lcd_seg_level[16 + gs];
				end else if (clock_stop) begin
					next_pin[gs] = '0;
				end else begin
					case (GRP)
						LPM_GRP_E: begin
							next_pin[gs].out = latch[LPM_LAT_E + B];
							next_pin[gs].oe  = pcw[LPM_PCW_E_DIR][B];
							if (sio2_on && B == 1) begin
								next_pin[gs].out = sio2_drv.sck_out;
								next_pin[gs].oe  = sio2_drv.sck_oe;
							end else if (sio2_on && B == 2) begin
								next_pin[gs].out = sio2_drv.so;
								next_pin[gs].oe  = 1'b1;
							end else if (sio2_on && B == 3) begin
								next_pin[gs].oe  = 1'b0;
							end
						end
						LPM_GRP_F: begin
							next_pin[gs].out = latch[LPM_LAT_F + B];
							next_pin[gs].oe  = pcw[LPM_PCW_F_DIR][B];
							if (sio1_on && B == 1) begin
								next_pin[gs].out = sio1_drv.sck_out;
								next_pin[gs].oe  = sio1_drv.sck_oe;
							end else if (sio1_on && B == 2) begin
								next_pin[gs].out = sio1_drv.so;
								next_pin[gs].oe  = 1'b1;
							end else if (sio1_on && B == 3) begin
								next_pin[gs].oe  = 1'b0;
							end
						end
						LPM_GRP_M: begin
							next_pin[gs].out = latch[LPM_LAT_M + B];
							next_pin[gs].oe  = pcw[LPM_PCW_M_DIR][B];
						end
						default: begin
							next_pin[gs].oe = 1'b1;
							if (B == 0 && beep_ctrl[LPM_BEEP_ROUTE]) begin
								next_pin[gs].out = beep_tone;
							end else begin
								next_pin[gs].out = latch[LPM_LAT_N + B];
							end
						end
					endcase
				end
			end

			// input seen only on an undriven port pin outside clock stop
			assign port_in_live[gs] = ~seg_mode[gs] & ~clock_stop &
				~shared_pin[gs].oe & shared_pin_in[gs];
		end
	endgenerate

	// shared pin drivers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shared_pin <= '0;
		end else begin
			shared_pin <= next_pin;
		end
	end

	// serial receive side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sio1_recv <= '0;
			sio2_recv <= '0;
		end else begin
			sio1_recv.sck_in <= sio1_on & port_in_live[5];
			sio1_recv.si     <= sio1_on & port_in_live[7];
			sio2_recv.sck_in <= sio2_on & port_in_live[1];
			sio2_recv.si     <= sio2_on & port_in_live[3];
		end
	end

	assign pin_in_view = {port_in_live, k_in_live};

endmodule

`default_nettype wire

// *** lpm_pkg.sv ***
/*
 * lpm_pkg: constants and carrier types for the lcd/port function multiplexer.
 * Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none

package lpm_pkg;

	// ==========================================================
	// timing
	localparam int unsigned LPM_CLK_PERIOD_NS   = 10;
	localparam int unsigned LPM_LCD_FRAME_NS    = 10_000_000;  // 100 Hz frame
	localparam int unsigned LPM_LCD_SLOTS       = 6;           // 3 commons x 2 polarities
	localparam int unsigned LPM_FRAME_CYCLES    = LPM_LCD_FRAME_NS / LPM_CLK_PERIOD_NS;
	localparam int unsigned LPM_PWM_PERIOD_NS   = 114_000;     // 1 / 8.77 kHz
	localparam int unsigned LPM_PWM_STEPS       = 256;
	localparam int unsigned LPM_PWM_STEP_CYCLES =
		LPM_PWM_PERIOD_NS / LPM_CLK_PERIOD_NS / LPM_PWM_STEPS;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] LPM_REG_PCW_BASE = 8'h00;  // 16 words, read back
	localparam logic [7:0] LPM_REG_PCW_CMD  = 8'h40;  // port number + value
	localparam logic [7:0] LPM_REG_STATUS   = 8'h44;
	localparam logic [7:0] LPM_REG_BEEP     = 8'h48;
	localparam logic [7:0] LPM_REG_LATCH    = 8'h4c;
	localparam logic [7:0] LPM_REG_PWM      = 8'h50;
	localparam logic [7:0] LPM_REG_SEG0     = 8'h58;
	localparam logic [7:0] LPM_REG_SEG1     = 8'h5c;
	localparam logic [7:0] LPM_REG_SEG2     = 8'h60;
	localparam logic [7:0] LPM_REG_PIN_IN   = 8'h64;

	// ==========================================================
	// port control word numbers and bits
	localparam logic [3:0] LPM_PCW_SIO_SEL = 4'h0;
	localparam logic [3:0] LPM_PCW_K_DIR   = 4'h2;
	localparam logic [3:0] LPM_PCW_EDGE    = 4'h3;
	localparam logic [3:0] LPM_PCW_E_DIR   = 4'h4;
	localparam logic [3:0] LPM_PCW_F_DIR   = 4'h5;
	localparam logic [3:0] LPM_PCW_J_SEL   = 4'h9;
	localparam logic [3:0] LPM_PCW_M_DIR   = 4'hc;
	localparam logic [3:0] LPM_PCW_E_SEG   = 4'hd;
	localparam logic [3:0] LPM_PCW_GRP_SEG = 4'he;
	localparam logic [3:0] LPM_PCW_RESET   = 4'h0;
	localparam int unsigned LPM_SIO1_BIT   = 1;
	localparam int unsigned LPM_SIO2_BIT   = 2;
	localparam int unsigned LPM_SEG_F_BIT  = 0;
	localparam int unsigned LPM_SEG_M_BIT  = 1;
	localparam int unsigned LPM_SEG_N_BIT  = 2;
	localparam int unsigned LPM_BEEP_ROUTE = 3;

	// status bits
	localparam int unsigned LPM_ST_MASTER  = 0;
	localparam int unsigned LPM_ST_IRQ_A   = 1;
	localparam int unsigned LPM_ST_IRQ_B   = 2;

	// port latch fields and reset value (open-drain bits released)
	localparam int unsigned LPM_LAT_J = 0;
	localparam int unsigned LPM_LAT_K = 4;
	localparam int unsigned LPM_LAT_E = 8;
	localparam int unsigned LPM_LAT_F = 12;
	localparam int unsigned LPM_LAT_M = 16;
	localparam int unsigned LPM_LAT_N = 20;
	localparam logic [23:0] LPM_LATCH_RESET = 24'h00000f;

	// ==========================================================
	// lcd drive levels
	localparam logic [1:0] LPM_LVL_VSS = 2'h0;
	localparam logic [1:0] LPM_LVL_1_3 = 2'h1;
	localparam logic [1:0] LPM_LVL_2_3 = 2'h2;
	localparam logic [1:0] LPM_LVL_VDD = 2'h3;

	typedef enum logic [1:0] {
		LPM_GRP_E = 2'b00,
		LPM_GRP_F = 2'b01,
		LPM_GRP_M = 2'b10,
		LPM_GRP_N = 2'b11
	} lpm_group_type;

	// one shared segment/port pin
	typedef struct packed {
		logic       seg_en;  // pin driven with lvl
		logic [1:0] lvl;     // lcd level when seg_en
		logic       out;     // port level when oe
		logic       oe;      // port driver on
	} lpm_pin_drive_type;

	// serial engine towards the pins
	typedef struct packed {
		logic sck_out;
		logic sck_oe;   // internal clock mode
		logic so;
	} lpm_sio_drv_type;

	// pins towards the serial engine
	typedef struct packed {
		logic sck_in;
		logic si;
	} lpm_sio_recv_type;

endpackage

`default_nettype wire

// *** lpm_pwm_chan.sv ***
/*
 * lpm_pwm_chan: one 8-bit pwm channel for an open-drain pin.
 * Assumes the duty value is held stable by its register.
 */
`timescale 1ns/1ps
`default_nettype none

module lpm_pwm_chan
	import lpm_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [7:0] duty,
	output logic            pwm_high
);

	// ==========================================================
	// period counters
	logic [15:0] step_cnt;
	logic [7:0]  phase;
	logic [7:0]  active_duty;
	logic        step_end;

	assign step_end = (step_cnt == 16'(LPM_PWM_STEP_CYCLES - 1));

	// step prescaler and phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt <= 16'h0000;
			phase    <= 8'h00;
		end else if (step_end) begin
			step_cnt <= 16'h0000;
			phase    <= phase + 8'h01;
		end else begin
			step_cnt <= step_cnt + 16'h0001;
		end
	end

	// new duty taken only at period end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_duty <= 8'h00;
		end else if (step_end && phase == 8'hff) begin
			active_duty <= duty;
		end
	end

	// output level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_high <= 1'b0;
		end else begin
			pwm_high <= (phase < active_duty);
		end
	end

endmodule

`default_nettype wire

// *** lpm_lcd_wave.sv ***
/*
 * lpm_lcd_wave: 1/3 duty, 1/3 bias common and segment waveforms.
 * Assumes segment data held in registers, one 32-bit word per common.
 */
`timescale 1ns/1ps
`default_nettype none

module lpm_lcd_wave
	import lpm_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = LPM_FRAME_CYCLES
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             run,
	input  wire logic [2:0][31:0] seg_data,
	output logic      [2:0][1:0]  com_lvl,
	output logic      [31:0][1:0] seg_lvl
);

	localparam int unsigned SLOT_CYCLES = FRAME_CYCLES / LPM_LCD_SLOTS;

	// ==========================================================
	// slot timing
	logic [31:0] cnt;
	logic [2:0]  slot;
	logic [1:0]  active;
	logic        neg;

	assign neg    = (slot >= 3'd3);
	assign active = neg ? 2'(slot - 3'd3) : slot[1:0];

	// six slots per 100 Hz frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt  <= 32'h00000000;
			slot <= 3'h0;
		end else if (cnt == SLOT_CYCLES - 1) begin
			cnt  <= 32'h00000000;
			slot <= (slot == 3'd5) ? 3'h0 : slot + 3'h1;
		end else begin
			cnt <= cnt + 32'h00000001;
		end
	end

	// commons: full swing when active, 1/3 or 2/3 otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			com_lvl <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (!run) begin
					com_lvl[c] <= LPM_LVL_VSS;
				end else if (active == 2'(c)) begin
					com_lvl[c] <= neg ? LPM_LVL_VSS : LPM_LVL_VDD;
				end else begin
					com_lvl[c] <= neg ? LPM_LVL_2_3 : LPM_LVL_1_3;
				end
			end
		end
	end

	// segments: opposite swing when lit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seg_lvl <= '0;
		end else begin
			for (int s = 0; s < 32; s++) begin
				if (!run) begin
					seg_lvl[s] <= LPM_LVL_VSS;
				end else if (seg_data[active][s]) begin
					seg_lvl[s] <= neg ? LPM_LVL_VDD : LPM_LVL_VSS;
				end else begin
					seg_lvl[s] <= neg ? LPM_LVL_1_3 : LPM_LVL_2_3;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** lpm_port_mux_assertions.sv ***
/* lpm_port_mux_assertions: port-level checks for the pin multiplexer.
   Assumes a single hclk domain, bound onto every lpm_port_mux. */
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module lpm_port_mux_assertions
	import lpm_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = LPM_FRAME_CYCLES
) (
	input wire logic                     hclk,
	input wire logic                     hresetn,
	input wire logic                     hreadyout,
	input wire logic                     hresp,
	input wire logic                     clock_stop,
	input wire logic [3:0]               irq_port_in,
	input wire logic [3:0]               open_drain_oe,
	input wire logic [3:0]               irq_port_oe,
	input wire logic                     ext_irq_a,
	input wire logic                     ext_irq_b,
	input wire logic [2:0][1:0]          lcd_common,
	input wire logic [31:0][1:0]         lcd_seg_level,
	input wire lpm_pin_drive_type [15:0] shared_pin
);
	logic stop_ok;
	// shared pins neither drive a port level nor a segment level other than VSS
	always_comb begin
		stop_ok = 1'b1;
		for (int i = 0; i < 16; i++)
			if (shared_pin[i].oe || shared_pin[i].lvl != LPM_LVL_VSS) stop_ok = 1'b0;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_always_okay: assert property (1'b1 |=> hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_stop_drain_off: assert property (clock_stop |=> open_drain_oe == 4'h0)
		else $error("open-drain transistor on in clock stop");
	a_stop_irq_float: assert property (clock_stop |=> irq_port_oe == 4'h0)
		else $error("interrupt port driven in clock stop");
	a_stop_lcd_low: assert property (clock_stop |=> lcd_common == '0 && lcd_seg_level[15:0] == '0)
		else $error("lcd lines not low in clock stop");
	a_stop_shared_pins: assert property (clock_stop |=> stop_ok)
		else $error("shared pin active in clock stop");
	a_irq_a_edge: assert property (ext_irq_a |-> $past(irq_port_in[0]) != $past(irq_port_in[0], 2))
		else $error("interrupt a without an input edge");
	a_irq_b_edge: assert property (ext_irq_b |-> $past(irq_port_in[1]) != $past(irq_port_in[1], 2))
		else $error("interrupt b without an input edge");
	a_irq_a_single: assert property (ext_irq_a |=> !ext_irq_a)
		else $error("interrupt a longer than one cycle");
endmodule

bind lpm_port_mux lpm_port_mux_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
	.hclk, .hresetn, .hreadyout, .hresp, .clock_stop, .irq_port_in, .open_drain_oe,
	.irq_port_oe, .ext_irq_a, .ext_irq_b, .lcd_common, .lcd_seg_level, .shared_pin);
`default_nettype wire

// *** lpm_far_model.sv ***
/* lpm_far_model: interrupt sources and port loads facing the pins.
   Assumes the bench supplies the far-side levels when pins are released. */
`timescale 1ns/1ps
`default_nettype none
// ====================
// far side
module lpm_far_model
	import lpm_pkg::*;
(
	input wire logic [3:0]               irq_port_out,
	input wire logic [3:0]               irq_port_oe,
	input wire logic [3:0]               irq_src,
	input wire lpm_pin_drive_type [15:0] shared_pin,
	input wire logic [15:0]              shared_src,
	output logic [3:0]                   irq_port_in,
	output logic [15:0]                  shared_pin_in
);
	// a pin shows the device's driver when on, else the far party's level
	always_comb begin
		for (int i = 0; i < 4; i++)
			irq_port_in[i] = irq_port_oe[i] ? irq_port_out[i] : irq_src[i];
		for (int i = 0; i < 16; i++)
			shared_pin_in[i] = (!shared_pin[i].seg_en && shared_pin[i].oe) ?
				shared_pin[i].out : shared_src[i];
	end
endmodule
`default_nettype wire

// *** lpm_port_mux_test.sv ***
/* lpm_port_mux_test: self-checking bench for the pin multiplexer.
   Assumes lpm_pkg, lpm_far_model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module lpm_port_mux_test
	import lpm_pkg::*;
;
	typedef struct packed {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] exp;
	} lpm_row_type;
	logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic                     clock_stop, beep_tone, ext_irq_a, ext_irq_b;
	logic [31:0]              haddr, hwdata, hrdata, rdv;
	logic [1:0]               htrans;
	logic [2:0]               hsize;
	logic [3:0]               irq_src, irq_port_in, open_drain_oe, irq_port_out, irq_port_oe;
	logic [15:0]              shared_src, shared_pin_in, seg_bits;
	logic [2:0][1:0]          lcd_common;
	logic [31:0][1:0]         lcd_seg_level;
	lpm_pin_drive_type [15:0] shared_pin;
	lpm_sio_drv_type          sio1_drv, sio2_drv;
	lpm_sio_recv_type         sio1_recv, sio2_recv;
	int                       failures, tests_run, cycles, irq_hits;
	lpm_row_type              rows [6] = '{
		'{LPM_REG_PCW_CMD, 32'h9f, 8'h24, 32'hf},
		'{LPM_REG_PCW_CMD, 32'he7, 8'h38, 32'h7},
		'{LPM_REG_STATUS, 32'h7, LPM_REG_STATUS, 32'h7},
		'{LPM_REG_BEEP, 32'hf, LPM_REG_BEEP, 32'hf},
		'{8'h70, 32'hffffffff, 8'h70, 32'h0},
		'{LPM_REG_PCW_CMD, 32'h35, LPM_REG_PCW_CMD, 32'h0}};

	lpm_port_mux #(.FRAME_CYCLES(60)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.clock_stop, .beep_tone, .sio1_drv, .sio2_drv, .irq_port_in, .shared_pin_in,
		.open_drain_oe, .irq_port_out, .irq_port_oe, .ext_irq_a, .ext_irq_b, .lcd_common,
		.lcd_seg_level, .shared_pin, .sio1_recv, .sio2_recv);
	lpm_far_model u_far (.irq_port_out, .irq_port_oe, .irq_src, .shared_pin, .shared_src,
		.irq_port_in, .shared_pin_in);

	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// cycle ceiling against hangs
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 15000) begin
			failures++;
			wrap_up();
		end
	end
	// count recognised interrupts
	always @(posedge hclk)
		if (ext_irq_a === 1'b1 || ext_irq_b === 1'b1) irq_hits++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single-word transfer: address phase, then data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task automatic settle;
		repeat (3) @(negedge hclk);
	endtask
	task automatic edge_in(input int b, input logic v);
		@(posedge hclk);
		irq_src[b] <= v;
		settle();
	endtask
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ====================
	// sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		clock_stop = 1'b0;
		beep_tone = 1'b0;
		sio1_drv = '0;
		sio2_drv = '0;
		irq_src = 4'h0;
		shared_src = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].wa, 1'b1, rows[i].wd);
			bus(rows[i].ra, 1'b0, 32'h0);
			chk(rdv, rows[i].exp);
		end
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk(32'({hreadyout, open_drain_oe, irq_port_oe, lcd_common}), 32'h0);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		settle();
		for (int i = 0; i < 16; i++)
			seg_bits[i] = shared_pin[i].seg_en;
		chk(32'(seg_bits), 32'hffff);
		chk(32'({open_drain_oe, irq_port_oe}), 32'h0);
		bus(LPM_REG_LATCH, 1'b0, 32'h0);
		chk(rdv, 32'hf);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h95);
		settle();
		chk(32'(open_drain_oe), 32'h5);
		@(posedge hclk);
		clock_stop <= 1'b1;
		settle();
		chk(32'(open_drain_oe), 32'h0);
		@(posedge hclk);
		clock_stop <= 1'b0;
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h23);
		bus(LPM_REG_LATCH, 1'b1, 32'h3f);
		settle();
		chk(32'(irq_port_oe), 32'h3);
		bus(LPM_REG_STATUS, 1'b1, 32'h2);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h31);
		settle();
		chk(32'(irq_port_oe), 32'h2);
		edge_in(0, 1'b1);
		chk(32'(irq_hits), 32'h0);
		bus(LPM_REG_STATUS, 1'b1, 32'h3);
		edge_in(0, 1'b0);
		edge_in(0, 1'b1);
		chk(32'(irq_hits), 32'h1);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h30);
		edge_in(1, 1'b1);
		bus(LPM_REG_STATUS, 1'b1, 32'h7);
		edge_in(0, 1'b0);
		edge_in(1, 1'b0);
		chk(32'(irq_hits), 32'h3);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'hd1);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h41);
		bus(LPM_REG_LATCH, 1'b1, 32'h13f);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'he4);
		bus(LPM_REG_BEEP, 1'b1, 32'h8);
		beep_tone <= 1'b1;
		settle();
		chk(32'({shared_pin[0].seg_en, shared_pin[0].out, shared_pin[0].oe}), 32'h3);
		chk(32'({shared_pin[12].out, shared_pin[15].oe, shared_pin[14].oe}), 32'h7);
		chk(32'({shared_pin[13].oe, shared_pin[4].seg_en}), 32'h3);
		@(posedge hclk);
		beep_tone <= 1'b0;
		bus(LPM_REG_LATCH, 1'b1, 32'h10013f);
		settle();
		chk(32'(shared_pin[12].out), 32'h0);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'h02);
		bus(LPM_REG_PCW_CMD, 1'b1, 32'he5);
		sio1_drv <= 3'h7;
		shared_src[7] <= 1'b1;
		settle();
		chk(32'({shared_pin[5], shared_pin[6]}), 32'h63);
		chk(32'({shared_pin[7].oe, sio1_recv.si}), 32'h1);
		bus(LPM_REG_PWM, 1'b1, 32'hff);
		settle();
		chk(32'(open_drain_oe[0]), 32'h1);
		for (int i = 0; i < 11400 && open_drain_oe[0]; i++)
			@(negedge hclk);
		chk(32'(open_drain_oe[0]), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
